// *** hw/gpio_pkg.sv ***
package gpio_pkg;
  localparam int PIN_COUNT = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] OFS_PIN_INPUT = 6'h00;
  localparam logic [5:0] OFS_DIRECTION = 6'h01;
  localparam logic [5:0] OFS_OUTPUT_VALUE = 6'h02;
  localparam logic [5:0] OFS_PULLUP_ENABLE = 6'h03;
  localparam logic [5:0] OFS_PORT_CONTROL = 6'h0c;
  localparam logic [5:0] OFS_MCU_CONTROL = 6'h0d;
  localparam logic [5:0] OFS_PIN_CHANGE_MASK = 6'h10;
  localparam logic [5:0] OFS_PIN_CHANGE_FLAGS = 6'h11;
  localparam logic [5:0] OFS_PIN_CHANGE_CONTROL = 6'h12;
  localparam logic [5:0] OFS_EXT_IRQ_MASK = 6'h13;
  localparam logic [5:0] OFS_EXT_IRQ_FLAGS = 6'h14;
  localparam logic [5:0] OFS_EXT_SENSE_CONTROL = 6'h15;
  localparam int BIT_FLAG = 0;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_BBM = 0;
  localparam int BIT_PUD = 4;
  localparam int EXT_PIN_INDEX = 2;
  localparam logic [3:0] RST_PORT_BITS = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  typedef enum logic [3:0] {
    SENSE_LOW_OH = 4'b0001,
    SENSE_ANY_OH = 4'b0010,
    SENSE_FALL_OH = 4'b0100,
    SENSE_RISE_OH = 4'b1000
  } sense_type;
endpackage

// *** hw/gpio_port.sv ***
`timescale 1ns/1ps
module gpio_port (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [gpio_pkg::ADDR_W-1:0] ioAddr,
  input wire logic ioWe,
  input wire logic [gpio_pkg::DATA_W-1:0] ioWdata,
  input wire logic ioRe,
  output logic [gpio_pkg::DATA_W-1:0] ioRdata,
  input wire logic bitOp,
  input wire logic [2:0] bitIdx,
  input wire logic bitVal,
  input wire logic globalIrqEnable,
  input wire logic extIrqAck,
  input wire logic pcIrqAck,
  output logic extIrqReq,
  output logic pcIrqReq,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] padIn,
  output logic [gpio_pkg::PIN_COUNT-1:0] padOut,
  output logic [gpio_pkg::PIN_COUNT-1:0] padOe,
  output logic [gpio_pkg::PIN_COUNT-1:0] padPullup
);
  import gpio_pkg::*;

  // Bit set/clear rides on the same address as a byte write
  function automatic logic [7:0] merge_bits(input logic [7:0] old,
      input logic [7:0] data, input logic [7:0] mask);
    merge_bits = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o,
      input logic w);
    hit = w && (a == o);
  endfunction

  logic [3:0] direction_reg_r;
  logic [3:0] dirPrev_r;
  logic [3:0] output_value_reg_r;
  logic [3:0] pullup_enable_reg_r;
  logic [3:0] pinSyncA_r;
  logic [3:0] pin_input_reg_r;
  logic [3:0] pinPrev_r;
  logic [3:0] pin_change_mask_r;
  logic pin_change_flag_r;
  logic pin_change_irq_enable_r;
  logic ext_irq_pin_mask_r;
  logic ext_irq_flag_r;
  logic [1:0] ext_sense_select_r;
  logic break_before_make_enable_r;
  logic global_pullup_disable_r;
  logic [7:0] readData_r;

  logic [3:0] direction_nxt;
  logic [3:0] output_value_nxt;
  logic [3:0] pullup_enable_nxt;
  logic [3:0] pin_change_mask_nxt;
  logic [7:0] readData_nxt;
  logic anyWrite;
  logic [7:0] wrMask;
  logic [7:0] wrData;
  logic [7:0] wrOnes;
  logic [3:0] toggleBits;
  logic [3:0] pinChanged;
  logic [3:0] dirRising;
  logic extNow;
  logic extPrev;
  logic extTrig;
  logic lowLevel;
  logic pcTrig;
  logic extFlagClr;
  logic pcFlagClr;
  logic ext_irq_flag_nxt;
  logic pin_change_flag_nxt;
  sense_type senseOh;
  logic [7:0] dirMerged;
  logic [7:0] outMerged;
  logic [7:0] pullMerged;
  logic [7:0] maskMerged;
  logic [7:0] senseMerged;
  logic [3:0] dirFalling;
  logic [3:0] keepBits;

  // Byte write replaces all bits; bit op touches one bit only
  assign anyWrite = ioWe || bitOp;
  assign wrMask = ioWe ? 8'hff : (8'h01 << bitIdx);
  assign wrData = ioWe ? ioWdata : ({7'h00, bitVal} << bitIdx);
  assign wrOnes = wrData & wrMask;

  assign dirMerged = merge_bits({4'h0, direction_reg_r}, wrData, wrMask);
  assign outMerged = merge_bits({4'h0, output_value_reg_r}, wrData, wrMask);
  assign pullMerged = merge_bits({4'h0, pullup_enable_reg_r}, wrData,
    wrMask);
  assign maskMerged = merge_bits({4'h0, pin_change_mask_r}, wrData, wrMask);
  assign senseMerged = merge_bits({6'h00, ext_sense_select_r}, wrData,
    wrMask);

  assign direction_nxt = hit(ioAddr, OFS_DIRECTION, anyWrite)
    ? dirMerged[3:0]
    : direction_reg_r;
  assign toggleBits = hit(ioAddr, OFS_PIN_INPUT, anyWrite)
    ? wrOnes[3:0] : 4'h0;
  assign output_value_nxt = (hit(ioAddr, OFS_OUTPUT_VALUE, anyWrite)
    ? outMerged[3:0]
    : output_value_reg_r) ^ toggleBits;
  assign pullup_enable_nxt = hit(ioAddr, OFS_PULLUP_ENABLE, anyWrite)
    ? pullMerged[3:0]
    : pullup_enable_reg_r;
  assign pin_change_mask_nxt = hit(ioAddr, OFS_PIN_CHANGE_MASK, anyWrite)
    ? maskMerged[3:0]
    : pin_change_mask_r;
  assign dirFalling = direction_reg_r & ~direction_nxt;
  assign keepBits = ~wrMask[3:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      direction_reg_r <= RST_PORT_BITS;
      dirPrev_r <= RST_PORT_BITS;
      output_value_reg_r <= RST_PORT_BITS;
      pullup_enable_reg_r <= RST_PORT_BITS;
      pin_change_mask_r <= RST_PORT_BITS;
    end else if (ce) begin
      direction_reg_r <= direction_nxt;
      dirPrev_r <= direction_reg_r;
      output_value_reg_r <= output_value_nxt;
      pullup_enable_reg_r <= pullup_enable_nxt;
      pin_change_mask_r <= pin_change_mask_nxt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_change_irq_enable_r <= 1'b0;
      ext_irq_pin_mask_r <= 1'b0;
      ext_sense_select_r <= SENSE_LOW;
      break_before_make_enable_r <= 1'b0;
      global_pullup_disable_r <= 1'b0;
    end else if (ce && anyWrite) begin
      if (ioAddr == OFS_PIN_CHANGE_CONTROL && wrMask[BIT_ENABLE]) begin
        pin_change_irq_enable_r <= wrData[BIT_ENABLE];
      end
      if (ioAddr == OFS_EXT_IRQ_MASK && wrMask[BIT_ENABLE]) begin
        ext_irq_pin_mask_r <= wrData[BIT_ENABLE];
      end
      if (ioAddr == OFS_EXT_SENSE_CONTROL) begin
        ext_sense_select_r <= senseMerged[1:0];
      end
      if (ioAddr == OFS_PORT_CONTROL && wrMask[BIT_BBM]) begin
        break_before_make_enable_r <= wrData[BIT_BBM];
      end
      if (ioAddr == OFS_MCU_CONTROL && wrMask[BIT_PUD]) begin
        global_pullup_disable_r <= wrData[BIT_PUD];
      end
    end
  end

  // Two flops stand in for latch plus register; edges use stage two only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinSyncA_r <= RST_PORT_BITS;
      pin_input_reg_r <= RST_PORT_BITS;
      pinPrev_r <= RST_PORT_BITS;
    end else if (ce) begin
      pinSyncA_r <= padIn;
      pin_input_reg_r <= pinSyncA_r;
      pinPrev_r <= pin_input_reg_r;
    end
  end

  // Sense decode; pins are sampled whatever their direction
  assign senseOh = sense_type'(4'h1 << ext_sense_select_r);
  assign extNow = pin_input_reg_r[EXT_PIN_INDEX];
  assign extPrev = pinPrev_r[EXT_PIN_INDEX];
  assign lowLevel = (senseOh == SENSE_LOW_OH);
  always_comb begin
    unique case (senseOh)
      SENSE_LOW_OH: extTrig = 1'b0;
      SENSE_ANY_OH: extTrig = extNow ^ extPrev;
      SENSE_FALL_OH: extTrig = extPrev && !extNow;
      SENSE_RISE_OH: extTrig = !extPrev && extNow;
      default: extTrig = 1'b0;
    endcase
  end

  assign pinChanged = pin_input_reg_r ^ pinPrev_r;
  assign pcTrig = |(pinChanged & pin_change_mask_r);

  assign extFlagClr = extIrqAck
    || (hit(ioAddr, OFS_EXT_IRQ_FLAGS, anyWrite) && wrOnes[BIT_FLAG]);
  assign pcFlagClr = pcIrqAck
    || (hit(ioAddr, OFS_PIN_CHANGE_FLAGS, anyWrite)
        && wrOnes[BIT_FLAG]);
  // A trigger in the clearing cycle survives the clear
  assign ext_irq_flag_nxt = lowLevel ? 1'b0
    : (extTrig || (ext_irq_flag_r && !extFlagClr));
  assign pin_change_flag_nxt = pcTrig
    || (pin_change_flag_r && !pcFlagClr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq_flag_r <= 1'b0;
      pin_change_flag_r <= 1'b0;
    end else if (ce) begin
      ext_irq_flag_r <= ext_irq_flag_nxt;
      pin_change_flag_r <= pin_change_flag_nxt;
    end
  end

  // Low-level requests follow the pin for as long as it is held low
  assign extIrqReq = globalIrqEnable && ext_irq_pin_mask_r
    && (lowLevel ? !extNow : ext_irq_flag_r);
  assign pcIrqReq = globalIrqEnable && pin_change_irq_enable_r
    && pin_change_flag_r;

  // Enable cleared by async reset, so pins float with no clock running
  // Per-pin terms plus the global break-before-make and pull-up-disable bits, so no pin's setting reaches another pin
  assign dirRising = direction_reg_r & ~dirPrev_r;
  assign padOe = direction_reg_r
    & ~({PIN_COUNT{break_before_make_enable_r}} & dirRising);
  assign padOut = output_value_reg_r;
  assign padPullup = pullup_enable_reg_r
    & {PIN_COUNT{!global_pullup_disable_r}};

  always_comb begin
    unique case (ioAddr)
      OFS_PIN_INPUT: readData_nxt = {4'h0, pin_input_reg_r};
      OFS_DIRECTION: readData_nxt = {4'h0, direction_reg_r};
      OFS_OUTPUT_VALUE: readData_nxt = {4'h0, output_value_reg_r};
      OFS_PULLUP_ENABLE: readData_nxt = {4'h0, pullup_enable_reg_r};
      OFS_PORT_CONTROL: readData_nxt = {7'h00, break_before_make_enable_r};
      OFS_MCU_CONTROL: readData_nxt = {3'h0, global_pullup_disable_r, 4'h0};
      OFS_PIN_CHANGE_MASK: readData_nxt = {4'h0, pin_change_mask_r};
      OFS_PIN_CHANGE_FLAGS: readData_nxt = {7'h00, pin_change_flag_r};
      OFS_PIN_CHANGE_CONTROL:
        readData_nxt = {7'h00, pin_change_irq_enable_r};
      OFS_EXT_IRQ_MASK: readData_nxt = {7'h00, ext_irq_pin_mask_r};
      OFS_EXT_IRQ_FLAGS: readData_nxt = {7'h00, ext_irq_flag_r};
      OFS_EXT_SENSE_CONTROL: readData_nxt = {6'h00, ext_sense_select_r};
      default: readData_nxt = RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readData_r <= RST_BYTE;
    end else if (ce && ioRe) begin
      readData_r <= readData_nxt;
    end
  end
  assign ioRdata = readData_r;

  // Checks
  logic [3:0] outputExpect;
  assign outputExpect = output_value_reg_r ^ wrOnes[3:0];

  sequence s_dir_turns_on;
    ce && break_before_make_enable_r && (dirRising != 4'h0);
  endsequence

  sequence s_pin_stable2;
    ce ##1 ce ##1 ce;
  endsequence

  a_ext_flag_set: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && extTrig && !lowLevel |=> ext_irq_flag_r)
    else $error("edge did not set external flag");
  a_ext_req_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    (!lowLevel && ext_irq_flag_r && globalIrqEnable && ext_irq_pin_mask_r)
    |-> extIrqReq)
    else $error("external request missing");
  a_ack_clears_flag: assert property (@(posedge mclk)
    disable iff (!arst_n)
    ce && pcIrqAck && !pcTrig |=> !pin_change_flag_r)
    else $error("ack did not clear pin-change flag");
  a_level_keeps_clear: assert property (@(posedge mclk)
    disable iff (!arst_n)
    ce && lowLevel |=> !ext_irq_flag_r)
    else $error("flag set in low-level mode");
  a_pc_req_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    pcIrqReq |-> globalIrqEnable && pin_change_irq_enable_r
    && pin_change_flag_r)
    else $error("pin-change request without enables");
  a_mask_blocks_pin: assert property (@(posedge mclk)
    disable iff (!arst_n)
    ce && !pin_change_flag_r && ((pinChanged & pin_change_mask_r) == 4'h0)
    |=> !pin_change_flag_r)
    else $error("masked pin set the flag");
  a_pc_flag_set: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && ((pinChanged & pin_change_mask_r) != 4'h0)
    |=> pin_change_flag_r)
    else $error("unmasked toggle missed");
  a_oe_needs_dir: assert property (@(posedge mclk) disable iff (!arst_n)
    (padOe & ~direction_reg_r) == 4'h0)
    else $error("input pin driven");
  a_bbm_gap: assert property (@(posedge mclk) disable iff (!arst_n)
    s_dir_turns_on |-> ((padOe & dirRising) == 4'h0)
    ##1 (padOe == direction_reg_r) || !ce)
    else $error("break-before-make gap wrong");
  a_toggle_write: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && anyWrite && ioAddr == OFS_PIN_INPUT
    |=> output_value_reg_r == $past(outputExpect))
    else $error("input register write did not toggle");
  a_pud_kills_pullup: assert property (@(posedge mclk)
    disable iff (!arst_n)
    global_pullup_disable_r |-> padPullup == 4'h0)
    else $error("pull-up active while disabled");
  a_sync_latency: assert property (@(posedge mclk) disable iff (!arst_n)
    s_pin_stable2 |-> pin_input_reg_r == $past(padIn, 2))
    else $error("synchroniser delay wrong");
  a_out_to_in: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && (dirFalling != 4'h0)
    |=> (padOe & $past(dirFalling)) == 4'h0)
    else $error("output to input delayed");
  a_bit_op_local: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && bitOp && !ioWe && ioAddr == OFS_DIRECTION
    |=> ((direction_reg_r ^ $past(direction_reg_r)) & $past(keepBits))
    == 4'h0)
    else $error("bit op changed other pins");
  a_pins_follow_dir: assert property (@(posedge mclk)
    disable iff (!arst_n)
    !break_before_make_enable_r |-> padOe == direction_reg_r)
    else $error("pin enable differs from direction");
  a_pad_value: assert property (@(posedge mclk) disable iff (!arst_n)
    padOut == output_value_reg_r
    && (padPullup & ~pullup_enable_reg_r) == 4'h0)
    else $error("pad value or pull-up wrong");
endmodule

// *** dv/pin_model.sv ***
`timescale 1ns/1ps
module pin_model (
  input wire logic mclk,
  input wire logic [3:0] padOut,
  input wire logic [3:0] padOe,
  input wire logic [3:0] padPullup,
  input wire logic [3:0] extDrive,
  input wire logic [3:0] extEn,
  output logic [3:0] padIn
);
  logic floatLvl_r = 1'h0;

  // A floating pin wanders, so no stale level can pass for a real one
  always @(posedge mclk) begin
    floatLvl_r <= ~floatLvl_r;
  end

  // The port's own driver wins over external circuitry on contention
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (extEn[i])
        padIn[i] = extDrive[i];
      else if (padPullup[i])
        padIn[i] = 1'h1;
      else
        padIn[i] = floatLvl_r;
    end
  end
endmodule

// *** dv/tb_gpio_port.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  nTests++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("ERROR %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb_gpio_port;
  import gpio_pkg::*;
  logic mclk = 1'h0;
  logic arst_n = 1'h1;
  logic ce = 1'h1;
  logic [5:0] ioAddr = 6'h00;
  logic ioWe = 1'h0;
  logic [7:0] ioWdata = 8'h00;
  logic ioRe = 1'h0;
  logic bitOp = 1'h0;
  logic [2:0] bitIdx = 3'h0;
  logic bitVal = 1'h0;
  logic globalIrqEnable = 1'h0;
  logic extIrqAck = 1'h0;
  logic pcIrqAck = 1'h0;
  logic [3:0] extDrive = 4'h0;
  logic [3:0] extEn = 4'hf;
  logic [7:0] ioRdata;
  logic extIrqReq;
  logic pcIrqReq;
  logic [3:0] padIn;
  logic [3:0] padOut;
  logic [3:0] padOe;
  logic [3:0] padPullup;
  int fails = 0;
  int nTests = 0;
  int cycles = 0;
  localparam logic [5:0] RST_OFS [4] = '{OFS_PIN_CHANGE_MASK,
    OFS_PIN_CHANGE_FLAGS, OFS_PIN_CHANGE_CONTROL, OFS_EXT_IRQ_FLAGS};
  localparam logic [1:0] SNS [6] = '{SENSE_RISE, SENSE_RISE,
    SENSE_FALL, SENSE_FALL, SENSE_ANY, SENSE_ANY};
  localparam logic [5:0] LVL = 6'h15;
  localparam logic [5:0] EXPF = 6'h39;

  gpio_port dut_u (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .ioAddr(ioAddr), .ioWe(ioWe), .ioWdata(ioWdata), .ioRe(ioRe),
    .ioRdata(ioRdata), .bitOp(bitOp), .bitIdx(bitIdx), .bitVal(bitVal),
    .globalIrqEnable(globalIrqEnable), .extIrqAck(extIrqAck),
    .pcIrqAck(pcIrqAck), .extIrqReq(extIrqReq), .pcIrqReq(pcIrqReq),
    .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup));

  pin_model far_u (.mclk(mclk), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .extDrive(extDrive), .extEn(extEn),
    .padIn(padIn));

  always #2.5 mclk = ~mclk;

  task test_done;
    $display("Checks %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      test_done;
    end
  end

  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    ioAddr <= a;
    ioWdata <= d;
    ioWe <= 1'h1;
    @(posedge mclk);
    ioWe <= 1'h0;
    #1;
  endtask

  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    ioAddr <= a;
    ioRe <= 1'h1;
    @(posedge mclk);
    ioRe <= 1'h0;
    #1;
    `CHK(ioRdata, e)
  endtask

  task bit_op(input logic [5:0] a, input logic [2:0] i, input logic v);
    @(posedge mclk);
    ioAddr <= a;
    bitIdx <= i;
    bitVal <= v;
    bitOp <= 1'h1;
    @(posedge mclk);
    bitOp <= 1'h0;
  endtask

  task waitc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task set_ext(input logic [3:0] v);
    @(posedge mclk);
    extDrive <= v;
    waitc(4);
  endtask

  task ack(input logic ext);
    @(posedge mclk);
    extIrqAck <= ext;
    pcIrqAck <= ~ext;
    @(posedge mclk);
    extIrqAck <= 1'h0;
    pcIrqAck <= 1'h0;
    #1;
  endtask

  initial begin
    arst_n <= 1'h0;
    #1;
    `CHK({padOe, padPullup}, 8'h00)
    repeat (20) @(posedge mclk);
    arst_n <= 1'h1;
    for (int i = 0; i < 4; i++) rd(RST_OFS[i], 8'h00);
    rd(6'h3f, 8'h00);
    wr(OFS_OUTPUT_VALUE, 8'h05);
    wr(OFS_DIRECTION, 8'h03);
    `CHK({padOe, padOut}, 8'h35)
    set_ext(4'h8);
    rd(OFS_PIN_INPUT, 8'h09);
    wr(OFS_PIN_INPUT, 8'h03);
    rd(OFS_OUTPUT_VALUE, 8'h06);
    bit_op(OFS_DIRECTION, 3'h3, 1'h1);
    rd(OFS_DIRECTION, 8'h0b);
    bit_op(OFS_DIRECTION, 3'h3, 1'h0);
    rd(OFS_DIRECTION, 8'h03);
    wr(OFS_PULLUP_ENABLE, 8'h0c);
    `CHK(padPullup, 4'hc)
    wr(OFS_MCU_CONTROL, 8'h10);
    `CHK(padPullup, 4'h0)
    wr(OFS_MCU_CONTROL, 8'h00);
    @(posedge mclk);
    ce <= 1'h0;
    wr(OFS_OUTPUT_VALUE, 8'h00);
    ce <= 1'h1;
    rd(OFS_OUTPUT_VALUE, 8'h06);
    // Direction writes stay three cycles apart in this mode
    wr(OFS_PORT_CONTROL, 8'h01);
    wr(OFS_DIRECTION, 8'h07);
    `CHK(padOe, 4'h3)
    waitc(1);
    `CHK(padOe, 4'h7)
    wr(OFS_DIRECTION, 8'h03);
    `CHK(padOe, 4'h3)
    wr(OFS_PORT_CONTROL, 8'h00);
    wr(OFS_PIN_CHANGE_MASK, 8'h04);
    set_ext(4'h0);
    rd(OFS_PIN_CHANGE_FLAGS, 8'h00);
    wr(OFS_PIN_CHANGE_CONTROL, 8'h01);
    set_ext(4'h4);
    rd(OFS_PIN_CHANGE_FLAGS, 8'h01);
    `CHK(pcIrqReq, 1'h0)
    @(posedge mclk);
    globalIrqEnable <= 1'h1;
    waitc(1);
    `CHK(pcIrqReq, 1'h1)
    ack(1'h0);
    `CHK(pcIrqReq, 1'h0)
    set_ext(4'h0);
    wr(OFS_PIN_CHANGE_FLAGS, 8'h00);
    rd(OFS_PIN_CHANGE_FLAGS, 8'h01);
    wr(OFS_PIN_CHANGE_FLAGS, 8'h01);
    rd(OFS_PIN_CHANGE_FLAGS, 8'h00);
    wr(OFS_EXT_IRQ_MASK, 8'h01);
    rd(OFS_EXT_IRQ_FLAGS, 8'h00);
    `CHK(extIrqReq, 1'h1)
    for (int i = 0; i < 6; i++) begin
      wr(OFS_EXT_SENSE_CONTROL, {6'h00, SNS[i]});
      wr(OFS_EXT_IRQ_FLAGS, 8'h01);
      set_ext({1'h0, LVL[i], 2'h0});
      rd(OFS_EXT_IRQ_FLAGS, {7'h00, EXPF[i]});
      `CHK(extIrqReq, EXPF[i])
    end
    ack(1'h1);
    `CHK(extIrqReq, 1'h0)
    wr(OFS_DIRECTION, 8'h07);
    waitc(4);
    rd(OFS_EXT_IRQ_FLAGS, 8'h01);
    arst_n <= 1'h0;
    #1;
    `CHK(padOe, 4'h0)
    @(posedge mclk);
    arst_n <= 1'h1;
    test_done;
  end
endmodule
